/* bench/osce_sys_model.sv */
`timescale 1ns/10ps
// stands in for the system controller that consumes outbound commands
module osce_sys_model (
    input wire logic clk_i,
    input wire logic tick_i,
    input wire logic [4:0] cmd_i,
    input wire logic valid_i,
    input wire logic [2:0] id_i,
    output logic link_clk_o
);
    logic [8:0] got[$]; // non-filler commands: id, validate bit, code
    int vic_held = 0; // victim entries the system has not flushed yet
    logic seen_nz = 1'b0; // nonzero filler has shown up
    int zero_late = 0; // zero fillers seen after the nonzero one
    // forwarded clock runs free, a command or a filler goes out on every rising edge
    initial begin
        link_clk_o = 1'b0;
        #23;
        forever #80 link_clk_o = ~link_clk_o;
    end
    // a command is taken in the one cycle its tick stands
    always @(posedge clk_i) begin
        if (tick_i === 1'b1) begin
            if (cmd_i === osce_pkg::CMD_NONZERO_IDLE) seen_nz = 1'b1;
            else if (cmd_i === osce_pkg::CMD_RESET_IDLE) zero_late += int'(seen_nz);
            else begin
                got.push_back({id_i, valid_i, cmd_i});
                // a flush request retires every victim entry sent before it
                if (cmd_i === osce_pkg::CMD_VB_FLUSH) vic_held = 0;
                else if (cmd_i[4:1] === 4'h2) vic_held++;
            end
        end
    end
endmodule

/* bench/outbound_system_command_encoder_tb_top.sv */
`timescale 1ns/10ps
module outbound_system_command_encoder_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, req_valid_i = 1'b0;
    logic req_hit_i = 1'b0, req_index_match_i = 1'b0, req_queue_empty_i = 1'b1; // queue idle
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [2:0] req_id_i = 3'h1, req_vic_id_i = 3'h5, cmd_id_o;
    logic [1:0] req_mask_i = 2'h0;
    osce_pkg::osce_kind_t req_kind_i = osce_pkg::OSCE_K_READ;
    osce_pkg::osce_vic_t req_vic_i = osce_pkg::OSCE_V_NONE;
    osce_pkg::osce_state_t req_state_i = osce_pkg::OSCE_S_CLEAN;
    logic link_clk_i, req_ready_o, ack_internal_o, validate_o, cmd_tick_o;
    logic [4:0] cmd_o;
    int bad_count = 0, n_checks = 0;
    // short reset period keeps the run brief
    osce_encoder #(.RESET_EDGES(2)) dut (.*);
    osce_sys_model sys (.clk_i(clk_i), .tick_i(cmd_tick_o), .cmd_i(cmd_o),
        .valid_i(validate_o), .id_i(cmd_id_o), .link_clk_o(link_clk_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    // one register cycle, write or read; read data taken the cycle after
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] g);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
        g = rdata_o;
    endtask
    // set config, offer one request, wait until ready again, judge commands
    task automatic s(input logic [9:0] cfg, input osce_pkg::osce_kind_t k, input logic [9:0] e,
        input int n, input osce_pkg::osce_vic_t v = osce_pkg::OSCE_V_NONE,
        input logic rv = 1'b1);
        int i;
        int t;
        logic seen;
        logic [4:0] c;
        logic [31:0] g;
        bus(1'b1, osce_pkg::OFS_CONFIG, {22'h0, cfg}, g);
        seen = 1'b0;
        t = 9999;
        sys.got.delete();
        req_valid_i <= 1'b1;
        req_kind_i <= k;
        req_vic_i <= v;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk_i);
            if (ack_internal_o === 1'b1) seen = 1'b1;
            // taken on this edge: drop the offer right after it
            if (req_valid_i === 1'b1 && req_ready_o === 1'b1) begin
                req_valid_i <= 1'b0;
                t = i;
            end
            if (i > t + 2 && req_ready_o === 1'b1) break;
        end
        if (i == 3000) begin
            bad_count++;
            print_verdict();
        end
        chk("internal ack", {31'h0, n == 0}, {31'h0, seen});
        chk("command count", n, sys.got.size());
        // victim commands and probe replies carry the victim buffer id
        for (i = 0; i < n; i++) begin
            c = e[9 - 5 * i -: 5];
            chk("command", {((i == 0) ? rv : 1'b1), c}, sys.got[i][5:0]);
            chk("command id", (c == 5'h01 || c[4:1] == 4'h2) ? 3'h5 : 3'h1, sys.got[i][8:6]);
        end
    endtask
    task automatic t_regs();
        int i;
        logic [31:0] g;
        g = 32'h0;
        for (i = 0; i < 100 && g[0] !== 1'b1; i++) bus(1'b0, osce_pkg::OFS_STATUS, 32'h0, g);
        chk("reset done", 32'h1, g);
        bus(1'b1, osce_pkg::OFS_CONFIG, 32'hffffffff, g);
        bus(1'b0, osce_pkg::OFS_CONFIG, 32'h0, g);
        chk("config", 32'h3ff, g);
        bus(1'b1, osce_pkg::OFS_STATUS, 32'hffffffff, g);
        bus(1'b0, osce_pkg::OFS_STATUS, 32'h0, g);
        chk("status", 32'h1, g);
        bus(1'b0, 4'h8, 32'h0, g);
        chk("unmapped", 32'h0, g);
    endtask
    task automatic t_reads();
        int k;
        for (k = 0; k < 4; k++) begin
            s(10'h000, osce_pkg::osce_kind_t'(2 + k), {5'h10 + 5'(k), 5'h0}, 1);
        end
        s(10'h002, osce_pkg::OSCE_K_READ, {5'h14, 5'h0}, 1);
        s(10'h002, osce_pkg::OSCE_K_FETCH, {5'h17, 5'h0}, 1);
        req_queue_empty_i <= 1'b0;
        s(10'h002, osce_pkg::OSCE_K_READ, {5'h10, 5'h0}, 1);
        req_queue_empty_i <= 1'b1;
        s(10'h000, osce_pkg::OSCE_K_READ, {5'h10, 5'h04}, 2, osce_pkg::OSCE_V_DIRTY);
        s(10'h004, osce_pkg::OSCE_K_READ, {5'h18, 5'h04}, 2, osce_pkg::OSCE_V_DIRTY);
        s(10'h00c, osce_pkg::OSCE_K_READ_MOD, {5'h19, 5'h05}, 2, osce_pkg::OSCE_V_CLEAN);
        s(10'h004, osce_pkg::OSCE_K_READ_INSTR, {5'h1a, 5'h04}, 2, osce_pkg::OSCE_V_DIRTY);
        s(10'h000, osce_pkg::OSCE_K_VICTIM, {5'h04, 5'h0}, 1, osce_pkg::OSCE_V_DIRTY);
        s(10'h000, osce_pkg::OSCE_K_PROBE, {5'h01, 5'h0}, 1);
        req_hit_i <= 1'b1;
        s(10'h000, osce_pkg::OSCE_K_READ, 10'h0, 0);
        s(10'h002, osce_pkg::OSCE_K_READ, {5'h14, 5'h0}, 1, osce_pkg::OSCE_V_NONE, 1'b0);
        req_hit_i <= 1'b0;
        req_index_match_i <= 1'b1;
        s(10'h000, osce_pkg::OSCE_K_READ, {5'h03, 5'h10}, 2);
        req_index_match_i <= 1'b0;
    endtask
    task automatic t_others();
        int j;
        s(10'h001, osce_pkg::OSCE_K_BARRIER, {5'h07, 5'h0}, 1);
        s(10'h000, osce_pkg::OSCE_K_BARRIER, 10'h0, 0);
        s(10'h010, osce_pkg::OSCE_K_EVICT, {5'h06, 5'h0}, 1);
        s(10'h014, osce_pkg::OSCE_K_EVICT, {5'h06, 5'h04}, 2, osce_pkg::OSCE_V_DIRTY);
        s(10'h000, osce_pkg::OSCE_K_EVICT, {5'h04, 5'h0}, 1, osce_pkg::OSCE_V_DIRTY);
        for (j = 0; j < 3; j++) begin
            req_mask_i <= 2'(j);
            s(10'h000, osce_pkg::OSCE_K_IO_READ, {5'h08 + 5'(j), 5'h0}, 1);
            s(10'h000, osce_pkg::OSCE_K_IO_WRITE, {5'h0c + 5'(j), 5'h0}, 1);
        end
        req_mask_i <= 2'h0;
    endtask
    // each set-dirty bit alone, then every bit but that one
    task automatic t_upgrades();
        int j;
        for (j = 0; j < 3; j++) begin
            req_state_i <= osce_pkg::osce_state_t'(j);
            s(10'h080 << j, osce_pkg::OSCE_K_UPGRADE,
                {(j == 0) ? 5'h1c : 5'h1d, 5'h0}, 1);
            s(10'h380 ^ (10'h080 << j), osce_pkg::OSCE_K_UPGRADE, 10'h0, 0);
        end
        s(10'h000, osce_pkg::OSCE_K_UPGRADE, 10'h0, 0);
        s(10'h380, osce_pkg::OSCE_K_STC_UPGRADE, {5'h1e, 5'h0}, 1);
        s(10'h060, osce_pkg::OSCE_K_WRITE_HINT, {5'h1f, 5'h0}, 1);
        s(10'h020, osce_pkg::OSCE_K_WRITE_HINT, 10'h0, 0);
        s(10'h000, osce_pkg::OSCE_K_WRITE_HINT, {5'h11, 5'h0}, 1);
        s(10'h064, osce_pkg::OSCE_K_WRITE_HINT, {5'h1b, 5'h04}, 2, osce_pkg::OSCE_V_DIRTY);
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_reads();
        t_others();
        t_upgrades();
        chk("late zero filler", 32'h0, sys.zero_late);
        chk("nonzero filler", 32'h1, {31'h0, sys.seen_nz});
        print_verdict();
    end
endmodule

/* design/osce_encoder.sv */
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module osce_encoder #(
    parameter int RESET_EDGES = osce_pkg::RESET_LINK_EDGES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic req_valid_i,
    input wire osce_pkg::osce_kind_t req_kind_i,
    input wire osce_pkg::osce_vic_t req_vic_i,
    input wire osce_pkg::osce_state_t req_state_i,
    input wire logic [1:0] req_mask_i,
    input wire logic [2:0] req_id_i,
    input wire logic [2:0] req_vic_id_i,
    input wire logic req_hit_i,
    input wire logic req_index_match_i,
    input wire logic req_queue_empty_i,
    output logic req_ready_o,
    output logic ack_internal_o,
    output logic [4:0] cmd_o,
    output logic validate_o,
    output logic [2:0] cmd_id_o,
    output logic cmd_tick_o
);
    // link clock synchroniser and edge finder
    logic link_s1_reg;
    logic link_s2_reg;
    logic link_s3_reg;
    logic link_tick;
    // forwarded-clock reset period
    logic [7:0] rst_cnt_reg;
    logic rst_done_reg;
    // software config
    logic [osce_pkg::CFG_WIDTH-1:0] cfg_reg;
    // pending commands, emitted in order one per link tick
    logic [4:0] slot_cmd_reg [3];
    logic slot_rv_reg [3];
    logic [2:0] slot_id_reg [3];
    logic [1:0] slot_cnt_reg;
    // planned commands for the request at the port
    logic [4:0] p_cmd [3];
    logic p_rv [3];
    logic [2:0] p_id [3];
    logic [1:0] p_cnt;
    logic p_ack;
    logic take;
    // decoded config bits
    logic barrier_en;
    logic spec_en;
    logic rdvic_en;
    logic clean_en;
    logic evict_en;
    logic [1:0] claim_en;
    logic [2:0] setd_en;

    assign barrier_en = cfg_reg[osce_pkg::CFG_BARRIER];
    assign spec_en = cfg_reg[osce_pkg::CFG_SPEC];
    assign rdvic_en = cfg_reg[osce_pkg::CFG_RDVIC];
    assign clean_en = cfg_reg[osce_pkg::CFG_CLEAN];
    assign evict_en = cfg_reg[osce_pkg::CFG_EVICT];
    assign claim_en = cfg_reg[osce_pkg::CFG_CLAIM_HI:osce_pkg::CFG_CLAIM_LO];
    assign setd_en = cfg_reg[osce_pkg::CFG_SETD_HI:osce_pkg::CFG_SETD_LO];
    assign take = req_valid_i && req_ready_o;
    assign link_tick = link_s2_reg && !link_s3_reg;

    // two flops before use; third only for the edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_s1_reg <= 1'b0;
            link_s2_reg <= 1'b0;
            link_s3_reg <= 1'b0;
        end else begin
            link_s1_reg <= link_clk_i;
            link_s2_reg <= link_s1_reg;
            link_s3_reg <= link_s2_reg;
        end
    end

    // count link edges until the reset period is over
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt_reg <= 8'h00;
            rst_done_reg <= 1'b0;
        end else if (!rst_done_reg && link_tick) begin
            // done flag never falls again, so zero filler stops for good
            if (rst_cnt_reg == 8'(RESET_EDGES - 1)) begin
                rst_done_reg <= 1'b1;
            end
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
        end
    end

    // config register write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= osce_pkg::CFG_RESET;
        end else if (wr_i && addr_i == osce_pkg::OFS_CONFIG) begin
            cfg_reg <= wdata_i[osce_pkg::CFG_WIDTH-1:0];
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                osce_pkg::OFS_CONFIG: begin
                    rdata_o <= {{(32-osce_pkg::CFG_WIDTH){1'b0}}, cfg_reg};
                end
                osce_pkg::OFS_STATUS: begin
                    rdata_o <= {30'h0, slot_cnt_reg != 2'd0, rst_done_reg};
                end
                default: begin
                    rdata_o <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // plan the command sequence for the offered request
    always_comb begin
        logic [4:0] base;
        logic has_vic;
        logic [4:0] vic_cmd;
        logic is_read;
        logic spec;
        base = osce_pkg::CMD_READ;
        has_vic = 1'b0;
        vic_cmd = osce_pkg::CMD_DIRTY_WB;
        is_read = 1'b0;
        spec = 1'b0;
        p_cnt = 2'd0;
        p_ack = 1'b0;
        for (int i = 0; i < 3; i++) begin
            p_cmd[i] = osce_pkg::CMD_NONZERO_IDLE;
            p_rv[i] = 1'b1;
            p_id[i] = req_id_i;
        end
        // clean victims only leave the chip when reporting is on
        if (req_vic_i == osce_pkg::OSCE_V_DIRTY) begin
            has_vic = 1'b1;
            vic_cmd = osce_pkg::CMD_DIRTY_WB;
        end else if (req_vic_i == osce_pkg::OSCE_V_CLEAN && clean_en) begin
            has_vic = 1'b1;
            vic_cmd = osce_pkg::CMD_CLEAN_NOTICE;
        end
        // flush request goes ahead of the transaction that collided
        if (req_index_match_i) begin
            p_cmd[0] = osce_pkg::CMD_VB_FLUSH;
            p_cnt = 2'd1;
        end
        case (req_kind_i)
            osce_pkg::OSCE_K_PROBE: begin
                p_cmd[p_cnt] = osce_pkg::CMD_PROBE_REPLY;
                p_id[p_cnt] = req_vic_id_i;
                p_cnt = p_cnt + 2'd1;
            end
            osce_pkg::OSCE_K_BARRIER: begin
                if (barrier_en) begin
                    p_cmd[p_cnt] = osce_pkg::CMD_BARRIER;
                    p_cnt = p_cnt + 2'd1;
                end else begin
                    p_ack = 1'b1;
                end
            end
            osce_pkg::OSCE_K_READ: begin
                base = osce_pkg::CMD_READ;
                is_read = 1'b1;
            end
            osce_pkg::OSCE_K_READ_MOD: begin
                base = osce_pkg::CMD_READ_MOD;
                is_read = 1'b1;
            end
            osce_pkg::OSCE_K_READ_INSTR: begin
                base = osce_pkg::CMD_READ_INSTR;
                is_read = 1'b1;
            end
            osce_pkg::OSCE_K_FETCH: begin
                base = osce_pkg::CMD_FETCH;
                is_read = 1'b1;
            end
            osce_pkg::OSCE_K_VICTIM: begin
                if (has_vic) begin
                    p_cmd[p_cnt] = vic_cmd;
                    p_id[p_cnt] = req_vic_id_i;
                    p_cnt = p_cnt + 2'd1;
                end else begin
                    p_ack = 1'b1;
                end
            end
            osce_pkg::OSCE_K_EVICT: begin
                if (evict_en) begin
                    p_cmd[p_cnt] = osce_pkg::CMD_EVICT;
                    p_cnt = p_cnt + 2'd1;
                end else if (!has_vic) begin
                    p_ack = 1'b1;
                end
                // victim rides right behind the evict, or alone
                if (has_vic) begin
                    p_cmd[p_cnt] = vic_cmd;
                    p_id[p_cnt] = req_vic_id_i;
                    p_cnt = p_cnt + 2'd1;
                end
            end
            osce_pkg::OSCE_K_IO_READ: begin
                p_cmd[p_cnt] = osce_pkg::CMD_IO_READ_BASE | {3'b000, req_mask_i};
                p_cnt = p_cnt + 2'd1;
            end
            osce_pkg::OSCE_K_IO_WRITE: begin
                p_cmd[p_cnt] = osce_pkg::CMD_IO_WRITE_BASE | {3'b000, req_mask_i};
                p_cnt = p_cnt + 2'd1;
            end
            osce_pkg::OSCE_K_UPGRADE, osce_pkg::OSCE_K_STC_UPGRADE: begin
                // one enable bit per block state, high to low DS/CS/C
                if ((req_state_i == osce_pkg::OSCE_S_CLEAN && setd_en[0]) ||
                    (req_state_i == osce_pkg::OSCE_S_CLEAN_SHARED && setd_en[1]) ||
                    (req_state_i == osce_pkg::OSCE_S_DIRTY_SHARED && setd_en[2])) begin
                    if (req_kind_i == osce_pkg::OSCE_K_STC_UPGRADE) begin
                        p_cmd[p_cnt] = osce_pkg::CMD_STC_UPG;
                    end else if (req_state_i == osce_pkg::OSCE_S_CLEAN) begin
                        p_cmd[p_cnt] = osce_pkg::CMD_CLEAN_UPG;
                    end else begin
                        p_cmd[p_cnt] = osce_pkg::CMD_SHARED_UPG;
                    end
                    p_cnt = p_cnt + 2'd1;
                end else begin
                    p_ack = 1'b1;
                end
            end
            osce_pkg::OSCE_K_WRITE_HINT: begin
                if (!claim_en[0]) begin
                    base = osce_pkg::CMD_READ_MOD;
                    is_read = 1'b1;
                end else if (!claim_en[1]) begin
                    p_ack = 1'b1;
                end else begin
                    if (rdvic_en && has_vic) begin
                        p_cmd[p_cnt] = osce_pkg::CMD_CLAIM_VIC;
                    end else begin
                        p_cmd[p_cnt] = osce_pkg::CMD_CLAIM;
                    end
                    p_cnt = p_cnt + 2'd1;
                    if (has_vic) begin
                        p_cmd[p_cnt] = vic_cmd;
                        p_id[p_cnt] = req_vic_id_i;
                        p_cnt = p_cnt + 2'd1;
                    end
                end
            end
            default: begin
                p_ack = 1'b1;
            end
        endcase
        // block reads: victim variant, speculative variant or plain
        if (is_read) begin
            spec = spec_en && req_queue_empty_i;
            if (rdvic_en && has_vic && base != osce_pkg::CMD_FETCH) begin
                p_cmd[p_cnt] = base | osce_pkg::CMD_VIC_BIT;
                p_cnt = p_cnt + 2'd1;
            end else if (spec) begin
                p_cmd[p_cnt] = base | osce_pkg::CMD_SPEC_BIT;
                p_rv[p_cnt] = !(req_hit_i || rdvic_en || req_vic_i != osce_pkg::OSCE_V_NONE);
                p_cnt = p_cnt + 2'd1;
            end else if (!req_hit_i) begin
                p_cmd[p_cnt] = base;
                p_cnt = p_cnt + 2'd1;
            end else if (!has_vic && !req_index_match_i) begin
                p_ack = 1'b1;
            end
            // victim sits directly behind its read, or goes alone when a hit sends no read
            if (has_vic) begin
                p_cmd[p_cnt] = vic_cmd;
                p_id[p_cnt] = req_vic_id_i;
                p_cnt = p_cnt + 2'd1;
            end
        end
    end

    // command slots: load on take, shift out on each link tick
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slot_cnt_reg <= 2'd0;
            for (int i = 0; i < 3; i++) begin
                slot_cmd_reg[i] <= osce_pkg::CMD_NONZERO_IDLE;
                slot_rv_reg[i] <= 1'b1;
                slot_id_reg[i] <= 3'h0;
            end
        end else if (take) begin
            slot_cnt_reg <= p_cnt;
            for (int i = 0; i < 3; i++) begin
                slot_cmd_reg[i] <= p_cmd[i];
                slot_rv_reg[i] <= p_rv[i];
                slot_id_reg[i] <= p_id[i];
            end
        end else if (link_tick && slot_cnt_reg != 2'd0) begin
            // shifting keeps pairs back to back with nothing between
            slot_cnt_reg <= slot_cnt_reg - 2'd1;
            for (int i = 0; i < 2; i++) begin
                slot_cmd_reg[i] <= slot_cmd_reg[i+1];
                slot_rv_reg[i] <= slot_rv_reg[i+1];
                slot_id_reg[i] <= slot_id_reg[i+1];
            end
        end
    end

    // ready only when slots empty, period over and no tick pending
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_ready_o <= 1'b0;
            ack_internal_o <= 1'b0;
        end else begin
            req_ready_o <= rst_done_reg && !take && !link_tick &&
                           (slot_cnt_reg == 2'd0 ||
                            (slot_cnt_reg == 2'd1 && link_tick));
            ack_internal_o <= take && p_ack;
        end
    end

    // link output: one command per tick, filler when nothing pending
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_o <= osce_pkg::CMD_RESET_IDLE;
            validate_o <= 1'b0;
            cmd_id_o <= 3'h0;
            cmd_tick_o <= 1'b0;
        end else begin
            cmd_tick_o <= link_tick;
            if (link_tick) begin
                if (!rst_done_reg) begin
                    cmd_o <= osce_pkg::CMD_RESET_IDLE;
                    validate_o <= 1'b0;
                    cmd_id_o <= 3'h0;
                end else if (slot_cnt_reg != 2'd0) begin
                    cmd_o <= slot_cmd_reg[0];
                    validate_o <= slot_rv_reg[0];
                    cmd_id_o <= slot_id_reg[0];
                end else begin
                    cmd_o <= osce_pkg::CMD_NONZERO_IDLE;
                    validate_o <= 1'b0;
                    cmd_id_o <= 3'h0;
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // the last zero filler still stands just after done rises; judge later ticks only
    chk_no_zero_after: assert property (rst_done_reg && link_tick
        |=> cmd_o != osce_pkg::CMD_RESET_IDLE)
        else $error("zero filler after reset period");
    chk_filler_idle: assert property (link_tick && rst_done_reg && slot_cnt_reg == 2'd0
        |=> cmd_o == osce_pkg::CMD_NONZERO_IDLE && cmd_tick_o)
        else $error("idle tick without nonzero filler");
    chk_barrier_gate: assert property (cmd_tick_o && cmd_o == osce_pkg::CMD_BARRIER |-> barrier_en)
        else $error("barrier sent while disabled");
    chk_spec_gate: assert property (cmd_tick_o && cmd_o[4:2] == 3'b101 |-> spec_en)
        else $error("speculative read while disabled");
    chk_rdvic_gate: assert property (cmd_tick_o && (cmd_o[4:3] == 2'b11 && cmd_o[2] == 1'b0
        || cmd_o == osce_pkg::CMD_CLAIM_VIC) |-> rdvic_en)
        else $error("victim read while disabled");
    chk_clean_gate: assert property (cmd_tick_o && cmd_o == osce_pkg::CMD_CLEAN_NOTICE
        |-> clean_en)
        else $error("clean notice while disabled");
    chk_evict_gate: assert property (cmd_tick_o && cmd_o == osce_pkg::CMD_EVICT |-> evict_en)
        else $error("evict sent while disabled");
    chk_vic_follows: assert property (take && p_cmd[0][4:3] == 2'b11 && p_cmd[0][2] == 1'b0
        && p_cnt == 2'd2 |=> slot_cnt_reg == 2'd2 && (slot_cmd_reg[1] == osce_pkg::CMD_DIRTY_WB
        || slot_cmd_reg[1] == osce_pkg::CMD_CLEAN_NOTICE))
        else $error("victim not queued behind its read");
    chk_nonspec_valid: assert property (cmd_tick_o && rst_done_reg && cmd_o[4:2] != 3'b101
        && cmd_o != osce_pkg::CMD_NONZERO_IDLE && cmd_o != osce_pkg::CMD_RESET_IDLE
        |-> validate_o)
        else $error("nonspeculative command without validate");
    chk_spec_hit_clear: assert property (take && spec_en && req_queue_empty_i && req_hit_i
        && req_kind_i == osce_pkg::OSCE_K_READ && !req_index_match_i
        && req_vic_i == osce_pkg::OSCE_V_NONE |=> slot_rv_reg[0] == 1'b0)
        else $error("speculative hit left validate set");
    chk_upg_off: assert property (take && setd_en == 3'b000
        && req_kind_i == osce_pkg::OSCE_K_UPGRADE |=> ack_internal_o)
        else $error("upgrade not acknowledged internally");

    cov_filler_switch: cover property (!rst_done_reg ##1 rst_done_reg);
    cov_rdvic_pair: cover property (cmd_tick_o && cmd_o == 5'h18 ##[1:40] cmd_tick_o
        && cmd_o == osce_pkg::CMD_DIRTY_WB);
    cov_spec_nop: cover property (cmd_tick_o && cmd_o == 5'h14 && !validate_o);
    cov_flush: cover property (cmd_tick_o && cmd_o == osce_pkg::CMD_VB_FLUSH);
endmodule

/* pkg/osce_pkg.sv */
// Function
// - zero filler during reset period only
// - nonzero filler on idle cycles afterwards
// - probe reply uses its own code
// - index match sends victim buffer flush
// - barrier notice only when export enabled
// - nonspeculative block read codes
// - speculative read codes only when enabled
// - read-with-victim codes only when enabled
// - dirty writeback code, clean notice when enabled
// - evict instruction makes evict command
// - victim follows evict atomically in victim mode
// - io read codes by mask size
// - io write codes by mask size
// - ownership upgrade codes
// - write hint claim codes, victim variant
// - speculative reads bypass when queue empty
// - validate bit clear on hit/victim/victim-mode
// - writeback directly after read-with-victim
// - clean notice directly after its read
// - three-bit upgrade enable per block state
// - two-bit write hint enable field
// - write hint enable encoding
// - upgrade enable encoding, 000 internal
// - validate bit set on nonspeculative commands
package osce_pkg;
    // command codes on the outbound link
    localparam logic [4:0] CMD_RESET_IDLE = 5'h00;
    localparam logic [4:0] CMD_PROBE_REPLY = 5'h01;
    localparam logic [4:0] CMD_NONZERO_IDLE = 5'h02;
    localparam logic [4:0] CMD_VB_FLUSH = 5'h03;
    localparam logic [4:0] CMD_DIRTY_WB = 5'h04;
    localparam logic [4:0] CMD_CLEAN_NOTICE = 5'h05;
    localparam logic [4:0] CMD_EVICT = 5'h06;
    localparam logic [4:0] CMD_BARRIER = 5'h07;
    localparam logic [4:0] CMD_IO_READ_BASE = 5'h08;
    localparam logic [4:0] CMD_IO_WRITE_BASE = 5'h0c;
    localparam logic [4:0] CMD_READ = 5'h10;
    localparam logic [4:0] CMD_READ_MOD = 5'h11;
    localparam logic [4:0] CMD_READ_INSTR = 5'h12;
    localparam logic [4:0] CMD_FETCH = 5'h13;
    localparam logic [4:0] CMD_SPEC_BIT = 5'h04;
    localparam logic [4:0] CMD_VIC_BIT = 5'h08;
    localparam logic [4:0] CMD_CLAIM_VIC = 5'h1b;
    localparam logic [4:0] CMD_CLEAN_UPG = 5'h1c;
    localparam logic [4:0] CMD_SHARED_UPG = 5'h1d;
    localparam logic [4:0] CMD_STC_UPG = 5'h1e;
    localparam logic [4:0] CMD_CLAIM = 5'h1f;
    // register offsets (byte addresses)
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    // config field positions
    localparam int CFG_BARRIER = 0;
    localparam int CFG_SPEC = 1;
    localparam int CFG_RDVIC = 2;
    localparam int CFG_CLEAN = 3;
    localparam int CFG_EVICT = 4;
    localparam int CFG_CLAIM_LO = 5;
    localparam int CFG_CLAIM_HI = 6;
    localparam int CFG_SETD_LO = 7;
    localparam int CFG_SETD_HI = 9;
    localparam int CFG_WIDTH = 10;
    localparam logic [9:0] CFG_RESET = 10'h000;
    // status field positions
    localparam int STS_RESET_DONE = 0;
    localparam int STS_BUSY = 1;
    // link edges in the forwarded-clock reset period
    localparam int RESET_LINK_EDGES = 16;
    // transaction kinds from the cache logic
    typedef enum logic [3:0] {
        OSCE_K_PROBE, OSCE_K_BARRIER, OSCE_K_READ, OSCE_K_READ_MOD, OSCE_K_READ_INSTR,
        OSCE_K_FETCH, OSCE_K_VICTIM, OSCE_K_EVICT, OSCE_K_IO_READ, OSCE_K_IO_WRITE,
        OSCE_K_UPGRADE, OSCE_K_STC_UPGRADE, OSCE_K_WRITE_HINT
    } osce_kind_t;
    // victim carried by a transaction
    typedef enum logic [1:0] {OSCE_V_NONE, OSCE_V_CLEAN, OSCE_V_DIRTY} osce_vic_t;
    // cached block state for upgrades
    typedef enum logic [1:0] {OSCE_S_CLEAN, OSCE_S_CLEAN_SHARED, OSCE_S_DIRTY_SHARED} osce_state_t;
endpackage
